//--- dv/i2csf_bus_model.sv
`timescale 1ns/1ps
module i2csf_bus_model (
  input  wire logic [2:0] ev,
  input  wire logic [7:0] dat,
  output logic            master_active,
  output logic            bus_collision,
  output logic            slave_active,
  output logic            addr10_second_match,
  output logic            stop_detected,
  output logic            tx_busy,
  output logic            rx_byte_done,
  output logic [7:0]      rx_shift_register
);
  assign master_active = ev == 3'h1;
  assign bus_collision = (ev == 3'h1) || (ev == 3'h6);
  assign slave_active = ev == 3'h2;
  assign addr10_second_match = ev == 3'h2;
  assign stop_detected = ev == 3'h3;
  assign rx_byte_done = ev == 3'h4;
  // The shift register shows inverted data outside a transfer so stale bytes never match.
  assign rx_shift_register = (ev == 3'h4) ? dat : ~dat;
  assign tx_busy = ev == 3'h5;
endmodule

//--- dv/i2csf_sva.sv
`timescale 1ns/1ps
module i2csf_sva
  import i2csf_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [3:0]  addr,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic        master_active,
  input wire logic        bus_collision,
  input wire logic        slave_active,
  input wire logic        addr10_second_match,
  input wire logic        stop_detected,
  input wire logic        tx_busy,
  input wire logic        wr_stb,
  input wire logic        rx_byte_done,
  input wire logic        tx_load
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd;
    rd_stb && addr == I2CSF_ADDR_STATUS;
  endsequence
  chk_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0000)
    else $error("rdata not idle");
  chk_unused_zero: assert property (s_rd |=> (rdata & 16'hFA3D) == 16'h0000)
    else $error("unused status bit set");
  chk_coll_seen: assert property (master_active && bus_collision ##1 s_rd |=> rdata[10])
    else $error("collision flag missing");
  chk_ten_bit_addr_matched_seen: assert property (slave_active && addr10_second_match ##1 s_rd |=> rdata[8])
    else $error("ten-bit flag missing");
  chk_stop_clear: assert property (stop_detected && !addr10_second_match ##1 s_rd |=> !rdata[8])
    else $error("ten-bit flag kept after stop");
  chk_busy_wr: assert property (wr_stb && addr == I2CSF_ADDR_TX_BUFFER && tx_busy |=> !tx_load)
    else $error("busy write was loaded");
  chk_rbf_set: assert property (rx_byte_done ##1 s_rd |=> rdata[1])
    else $error("buffer full flag missing");
  chk_ovf_set: assert property (rx_byte_done ##1 rx_byte_done ##1 s_rd |=> rdata[6])
    else $error("overflow flag missing");
endmodule
bind i2csf_status i2csf_sva i2csf_sva_inst (.*);

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import i2csf_pkg::*;
  localparam logic [3:0] ST = I2CSF_ADDR_STATUS;
  localparam logic [3:0] IS = I2CSF_ADDR_IRQ_STAT;
  logic        sys_clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [2:0]  ev = 3'h0;
  logic [7:0]  dat = 8'h00, tx_buffer, rx_shift_register;
  logic        master_active, bus_collision, slave_active, addr10_second_match;
  logic        stop_detected, tx_busy, rx_byte_done, tx_load, irq;
  int          miscompares = 0, checked = 0, cyc = 0, loads = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (resetn && tx_load === 1'b1) begin
      loads <= loads + 1;
    end
  end
  i2csf_status i2csf_status_inst (.*);
  i2csf_bus_model i2csf_bus_model_inst (.*);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    chk(n, e, rdata);
    @(posedge sys_clk);
  endtask
  task automatic evt(input logic [2:0] c, input logic [7:0] d);
    ev <= c;
    dat <= d;
    @(posedge sys_clk);
    ev <= 3'h0;
  endtask
  task automatic rx_pair(input logic [7:0] d0, input logic [7:0] d1);
    ev <= 3'h4;
    dat <= d0;
    @(posedge sys_clk);
    dat <= d1;
    @(posedge sys_clk);
    ev <= 3'h0;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc("status", ST, 16'h0000);
    rdc("irq_stat", IS, 16'h0000);
    wr(I2CSF_ADDR_IRQ_MASK, 16'h003F);
    rdc("irq_mask", I2CSF_ADDR_IRQ_MASK, 16'h003F);
    evt(3'h1, 8'h00);
    rdc("coll", ST, 16'h0400);
    #1 chk("irq", 16'h0001, {15'h0000, irq});
    wr(ST, 16'h0400);
    rdc("coll_clr", ST, 16'h0000);
    evt(3'h6, 8'h00);
    rdc("coll_slave", ST, 16'h0000);
    evt(3'h2, 8'h00);
    rdc("ten_bit_addr_matched", ST, 16'h0100);
    wr(ST, 16'h0100);
    rdc("ten_bit_addr_matched_held", ST, 16'h0100);
    evt(3'h3, 8'h00);
    rdc("ten_bit_addr_matched_stop", ST, 16'h0000);
    ev <= 3'h5;
    wr(I2CSF_ADDR_TX_BUFFER, 16'h005A);
    ev <= 3'h0;
    #1 chk("tx_busy_buf", 16'h0000, {8'h00, tx_buffer});
    chk("tx_load_none", 16'h0000, 16'(loads));
    wr(ST, 16'h0000);
    rdc("wcol", ST, 16'h0080);
    wr(ST, 16'h0080);
    wr(I2CSF_ADDR_TX_BUFFER, 16'h00A5);
    rdc("wcol_clr", ST, 16'h0000);
    chk("tx_buf", 16'h00A5, {8'h00, tx_buffer});
    chk("tx_load_cnt", 16'h0001, 16'(loads));
    rdc("tx_rd", I2CSF_ADDR_TX_BUFFER, 16'h00A5);
    rx_pair(8'h3C, 8'hC3);
    rdc("ovf", ST, 16'h0042);
    rdc("rx_buf", I2CSF_ADDR_RX_BUFFER, 16'h003C);
    wr(ST, 16'h0000);
    rdc("ovf_held", ST, 16'h0040);
    wr(ST, 16'h0040);
    rdc("ovf_clr", ST, 16'h0000);
    rdc("irq_all", IS, 16'h001F);
    wr(I2CSF_ADDR_IRQ_MASK, 16'h0000);
    rdc("unmapped", 4'hF, 16'h0000);
    #1 chk("irq_off", 16'h0000, {15'h0000, irq});
    wr(4'hF, 16'hFFFF);
    wr(IS, 16'h003F);
    rdc("irq_clr", IS, 16'h0000);
    rdc("status_end", ST, 16'h0000);
    wr(I2CSF_ADDR_IRQ_MASK, 16'h003F);
    evt(3'h1, 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc("status_rst", ST, 16'h0000);
    rdc("mask_rst", I2CSF_ADDR_IRQ_MASK, 16'h0000);
    #1 chk("irq_rst", 16'h0000, {15'h0000, irq});
    tally_and_finish;
  end
endmodule

//--- rtl/i2csf_flag_if.sv
`timescale 1ns/1ps
interface i2csf_flag_if;
  logic set_pulse;
  logic clr_pulse;
  logic flag;
  modport owner (input set_pulse, input clr_pulse, output flag);
  modport user  (output set_pulse, output clr_pulse, input flag);
endinterface

//--- rtl/i2csf_pkg.sv
package i2csf_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0]  I2CSF_ADDR_STATUS = 4'h0;
  localparam logic [3:0]  I2CSF_ADDR_IRQ_MASK = 4'h1;
  localparam logic [3:0]  I2CSF_ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0]  I2CSF_ADDR_RX_BUFFER = 4'h3;
  localparam logic [3:0]  I2CSF_ADDR_TX_BUFFER = 4'h4;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int          I2CSF_BIT_COLLISION = 10;
  localparam int          I2CSF_BIT_TEN_BIT_ADDR_MATCHED = 8;
  localparam int          I2CSF_BIT_WCOL = 7;
  localparam int          I2CSF_BIT_OVF = 6;
  localparam int          I2CSF_BIT_RBF = 1;

  // ----------------------------------------
  // Interrupt status positions
  // ----------------------------------------
  localparam int          I2CSF_IRQ_COLLISION = 0;
  localparam int          I2CSF_IRQ_TEN_BIT_ADDR_MATCHED = 1;
  localparam int          I2CSF_IRQ_WCOL = 2;
  localparam int          I2CSF_IRQ_OVF = 3;
  localparam int          I2CSF_IRQ_RX = 4;
  localparam int          I2CSF_IRQ_W = 5;

  localparam logic [15:0] I2CSF_STATUS_RESET = 16'h0000;
  localparam logic [15:0] I2CSF_ZERO16 = 16'h0000;

endpackage

//--- rtl/i2csf_status.sv
// How it works
// R1: Bus collision during master operation sets the collision flag; otherwise it reads zero.
// R2: Slave match of second ten-bit address byte sets the ten-bit matched flag.
// R3: A Stop condition on the bus clears the ten-bit matched flag.
// R4: Writing transmit buffer while busy sets write collision, held until software clears.
// R5: Shift-to-buffer transfer while receive buffer still full sets receive overflow.
// R6: Receive overflow stays set until software clears it; hardware never clears.
// R7: Received byte written sets buffer full; software read of buffer clears it.
// R8: Flags reset to zero; unused status bit positions always read zero.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module i2csf_status
  import i2csf_pkg::*;
#(
  parameter int DATA_W = 8
)(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [15:0]       rdata,
  input  wire logic              master_active,
  input  wire logic              bus_collision,
  input  wire logic              slave_active,
  input  wire logic              addr10_second_match,
  input  wire logic              stop_detected,
  input  wire logic              tx_busy,
  input  wire logic              rx_byte_done,
  input  wire logic [DATA_W-1:0] rx_shift_register,
  output logic      [DATA_W-1:0] tx_buffer,
  output logic                   tx_load,
  output logic                   irq
);

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  i2csf_flag_if col_fl ();
  i2csf_flag_if a10_fl ();
  i2csf_flag_if wc_fl ();
  i2csf_flag_if ov_fl ();
  i2csf_flag_if rbf_fl ();

  logic tx_wr;
  logic rx_rd;
  logic ev_coll;
  logic ev_ten_bit_addr_matched;
  logic ev_wcol;
  logic ev_ovf;
  logic ev_rx;

  assign tx_wr = wr_stb && (addr == I2CSF_ADDR_TX_BUFFER);
  assign rx_rd = rd_stb && (addr == I2CSF_ADDR_RX_BUFFER);
  // R1: collision during master
  assign ev_coll = bus_collision && master_active;
  // R2: second address byte
  assign ev_ten_bit_addr_matched = slave_active && addr10_second_match;
  // R4: write while busy
  assign ev_wcol = tx_wr && tx_busy;
  // R5: transfer onto full buffer
  assign ev_ovf = rx_byte_done && rbf_fl.flag;
  assign ev_rx = rx_byte_done && !rbf_fl.flag;

  // The strobe is an argument so a continuous assignment re-evaluates when it drops.
  function automatic logic clr_hit(input logic s, input logic [3:0] a, input logic [3:0] reg_a,
                                   input logic [15:0] d, input int pos);
    clr_hit = s && (a == reg_a) && d[pos];
  endfunction

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  assign col_fl.set_pulse = ev_coll;
  assign col_fl.clr_pulse = clr_hit(wr_stb, addr, I2CSF_ADDR_STATUS, wdata, I2CSF_BIT_COLLISION);
  assign a10_fl.set_pulse = ev_ten_bit_addr_matched;
  // R3: stop clears matched
  assign a10_fl.clr_pulse = stop_detected;
  assign wc_fl.set_pulse = ev_wcol;
  assign wc_fl.clr_pulse = clr_hit(wr_stb, addr, I2CSF_ADDR_STATUS, wdata, I2CSF_BIT_WCOL);
  assign ov_fl.set_pulse = ev_ovf;
  // R6: only software clears
  assign ov_fl.clr_pulse = clr_hit(wr_stb, addr, I2CSF_ADDR_STATUS, wdata, I2CSF_BIT_OVF);
  // R7: fill and read
  assign rbf_fl.set_pulse = ev_rx;
  assign rbf_fl.clr_pulse = rx_rd;

  i2csf_sticky u_col (.sys_clk(sys_clk), .resetn(resetn), .fl(col_fl));
  i2csf_sticky u_a10 (.sys_clk(sys_clk), .resetn(resetn), .fl(a10_fl));
  i2csf_sticky u_wc  (.sys_clk(sys_clk), .resetn(resetn), .fl(wc_fl));
  i2csf_sticky u_ov  (.sys_clk(sys_clk), .resetn(resetn), .fl(ov_fl));
  i2csf_sticky u_rbf (.sys_clk(sys_clk), .resetn(resetn), .fl(rbf_fl));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [DATA_W-1:0] rx_buf_r;
  logic [DATA_W-1:0] rx_buf_nxt;
  logic [DATA_W-1:0] tx_buf_r;
  logic [DATA_W-1:0] tx_buf_nxt;
  logic              tx_load_r;
  logic              tx_load_nxt;
  logic [5:0]        irq_mask_r;
  logic [5:0]        irq_mask_nxt;
  logic [5:0]        irq_stat_r;
  logic [5:0]        irq_stat_nxt;
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic [15:0]       status_word;
  logic [5:0]        irq_ev;

  // R8: unused bits read zero
  always_comb begin
    status_word = I2CSF_STATUS_RESET;
    status_word[I2CSF_BIT_COLLISION] = col_fl.flag;
    status_word[I2CSF_BIT_TEN_BIT_ADDR_MATCHED] = a10_fl.flag;
    status_word[I2CSF_BIT_WCOL] = wc_fl.flag;
    status_word[I2CSF_BIT_OVF] = ov_fl.flag;
    status_word[I2CSF_BIT_RBF] = rbf_fl.flag;
  end

  always_comb begin
    irq_ev = 6'h00;
    irq_ev[I2CSF_IRQ_COLLISION] = ev_coll;
    irq_ev[I2CSF_IRQ_TEN_BIT_ADDR_MATCHED] = ev_ten_bit_addr_matched;
    irq_ev[I2CSF_IRQ_WCOL] = ev_wcol;
    irq_ev[I2CSF_IRQ_OVF] = ev_ovf;
    irq_ev[I2CSF_IRQ_RX] = ev_rx;
    irq_ev[I2CSF_IRQ_W] = 1'b0;
  end

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  // The overflowing byte is dropped so the unread one stays intact.
  always_comb begin
    rx_buf_nxt = rx_buf_r;
    if (ev_rx) begin
      rx_buf_nxt = rx_shift_register;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_buf_r <= '0;
    end else begin
      rx_buf_r <= rx_buf_nxt;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  // R4: busy write refused
  always_comb begin
    tx_buf_nxt  = tx_buf_r;
    tx_load_nxt = 1'b0;
    if (tx_wr && !tx_busy) begin
      tx_buf_nxt  = wdata[DATA_W-1:0];
      tx_load_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_buf_r  <= '0;
      tx_load_r <= 1'b0;
    end else begin
      tx_buf_r  <= tx_buf_nxt;
      tx_load_r <= tx_load_nxt;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // The new mask is used at once so the output never shows a request that was just masked.
  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (wr_stb && addr == I2CSF_ADDR_IRQ_MASK) begin
      irq_mask_nxt = wdata[5:0];
    end
    irq_stat_nxt = irq_stat_r;
    if (wr_stb && addr == I2CSF_ADDR_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~wdata[5:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_ev;
    irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_mask_r <= 6'h00;
      irq_stat_r <= 6'h00;
      irq_r      <= 1'b0;
    end else begin
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_nxt = I2CSF_ZERO16;
    if (rd_stb) begin
      case (addr)
        I2CSF_ADDR_STATUS:    rdata_nxt = status_word;
        I2CSF_ADDR_IRQ_MASK:  rdata_nxt = {10'h000, irq_mask_r};
        I2CSF_ADDR_IRQ_STAT:  rdata_nxt = {10'h000, irq_stat_r};
        I2CSF_ADDR_RX_BUFFER: rdata_nxt = 16'(rx_buf_r);
        I2CSF_ADDR_TX_BUFFER: rdata_nxt = 16'(tx_buf_r);
        default:              rdata_nxt = I2CSF_ZERO16;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata     = rdata_r;
  assign tx_buffer = tx_buf_r;
  assign tx_load   = tx_load_r;
  assign irq       = irq_r;

endmodule

//--- rtl/i2csf_sticky.sv
`timescale 1ns/1ps
module i2csf_sticky
  import i2csf_pkg::*;
(
  input wire logic    sys_clk,
  input wire logic    resetn,
  i2csf_flag_if.owner fl
);

  logic flag_r;
  logic flag_nxt;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_comb begin
    flag_nxt = flag_r;
    if (fl.clr_pulse) begin
      flag_nxt = 1'b0;
    end
    if (fl.set_pulse) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign fl.flag = flag_r;

endmodule
